// ===== core/dshbp_pkg.sv
// Shared types and constants of the dual-style host bus port
package dshbp_pkg;

	// Level of the bus-style strap that picks the two-strobe style
	localparam logic STYLE_DUAL = 1'b1;
	// Level of the direction line that asks for a read in single-strobe style
	localparam logic DIR_READ = 1'b1;
	// Channel codes, also the value of the channel pick bit
	localparam logic CHAN_FIRST = 1'b0;
	localparam logic CHAN_SECOND = 1'b1;
	// Idle level of every active-low strobe and select, used as reset value
	localparam logic STROBE_IDLE = 1'b1;
	// Reset values of the pin-facing outputs
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic READY_N_RST = 1'b1;
	localparam logic AUX_OUT2_N_RST = 1'b1;
	// Width of the bundle of pin inputs that go through the synchroniser
	localparam int PIN_BUNDLE_W = 16;

	// Bus cycle tracking
	typedef enum logic [1:0] {
		DSHBP_IDLE,
		DSHBP_READ,
		DSHBP_WRITE
	} dshbp_cyc_t;

	// Pin inputs after synchronisation
	typedef struct packed {
		logic bus_style;
		logic read_strobe_n;
		logic write_strobe_n;
		logic first_channel_select_n;
		logic second_channel_select_n;
		logic [2:0] reg_addr;
		logic [7:0] data;
	} dshbp_pins_t;

	// One register access toward the channel register files
	typedef struct packed {
		logic rd;
		logic wr;
		logic chan;
		logic [2:0] addr;
		logic [7:0] wdata;
	} dshbp_acc_t;

	// Status that one channel hands to the port
	typedef struct packed {
		logic irq;
		logic out2_ctrl_bit;
		logic tx_ready;
		logic rx_ready;
	} dshbp_chan_stat_t;

endpackage

// ===== core/dshbp_port.sv
// Host bus port of a two-channel UART: two bus styles, interrupt and ready pins
`timescale 1ns/10ps
`default_nettype none
module dshbp_port
	import dshbp_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// Host bus pins
	input wire logic bus_style_i,
	input wire logic read_strobe_n_i,
	input wire logic write_strobe_n_i,
	input wire logic first_channel_select_n_i,
	input wire logic second_channel_select_n_i,
	input wire logic reg_addr_bit2_i,
	input wire logic reg_addr_bit1_i,
	input wire logic reg_addr_bit0_i,
	input wire logic [7:0] data_i,
	output logic [7:0] data_o,
	output logic data_oe_o,
	// Interrupt and auxiliary pins
	output logic first_channel_irq_o,
	output logic first_channel_irq_oe_o,
	output logic second_channel_irq_o,
	output logic second_channel_irq_oe_o,
	output logic first_aux_out2_n_o,
	output logic second_aux_out2_n_o,
	// Ready pins
	output logic first_tx_ready_n_o,
	output logic first_rx_ready_n_o,
	output logic second_tx_ready_n_o,
	output logic second_rx_ready_n_o,
	// Register access toward the channels
	output dshbp_acc_t acc_o,
	input wire logic [7:0] first_rd_data_i,
	input wire logic [7:0] second_rd_data_i,
	// Channel status
	input wire dshbp_chan_stat_t first_stat_i,
	input wire dshbp_chan_stat_t second_stat_i
);

	dshbp_pins_t pins_async;
	dshbp_pins_t pins_rst;
	dshbp_pins_t pins;
	logic rd_n_prev_r;
	logic wr_n_prev_r;
	logic cs_prev_r;
	dshbp_cyc_t cyc_r;
	logic cyc_chan_r;
	logic rd_fill_r;
	dshbp_acc_t acc_r;
	logic [7:0] data_r;
	logic dual;
	logic start_rd;
	logic start_wr;
	logic end_rd;
	logic end_wr;
	logic sel_chan;

	assign pins_async = '{
		bus_style: bus_style_i,
		read_strobe_n: read_strobe_n_i,
		write_strobe_n: write_strobe_n_i,
		first_channel_select_n: first_channel_select_n_i,
		second_channel_select_n: second_channel_select_n_i,
		reg_addr: {reg_addr_bit2_i, reg_addr_bit1_i, reg_addr_bit0_i},
		data: data_i
	};

	assign pins_rst = '{
		bus_style: STYLE_DUAL,
		read_strobe_n: STROBE_IDLE,
		write_strobe_n: STROBE_IDLE,
		first_channel_select_n: STROBE_IDLE,
		second_channel_select_n: STROBE_IDLE,
		reg_addr: 3'h0,
		data: DATA_RST
	};

	// Every pin passes two flops before the edge logic sees it
	dshbp_sync u_sync (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.async_i(pins_async),
		.rst_val_i(pins_rst),
		.sync_o(pins)
	);

	assign dual = (pins.bus_style == STYLE_DUAL);

	// Previous levels for edge detection, taken from the synchronised copies only
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			rd_n_prev_r <= STROBE_IDLE;
			wr_n_prev_r <= STROBE_IDLE;
			cs_prev_r <= STROBE_IDLE;
		end else begin
			rd_n_prev_r <= pins.read_strobe_n;
			wr_n_prev_r <= pins.write_strobe_n;
			cs_prev_r <= pins.first_channel_select_n;
		end
	end

	// Cycle start and end events for both bus styles
	always_comb begin
		start_rd = 1'b0;
		start_wr = 1'b0;
		end_rd = 1'b0;
		end_wr = 1'b0;
		sel_chan = CHAN_FIRST;
		if (dual) begin
			// First select wins when the host lowers both
			if (!pins.first_channel_select_n) begin
				sel_chan = CHAN_FIRST;
			end else begin
				sel_chan = CHAN_SECOND;
			end
			if (!pins.first_channel_select_n || !pins.second_channel_select_n) begin
				start_rd = rd_n_prev_r && !pins.read_strobe_n;
				start_wr = wr_n_prev_r && !pins.write_strobe_n;
			end
			end_rd = !rd_n_prev_r && pins.read_strobe_n;
			end_wr = !wr_n_prev_r && pins.write_strobe_n;
		end else begin
			// Read strobe pin plays no part here
			sel_chan = pins.second_channel_select_n;
			if (cs_prev_r && !pins.first_channel_select_n) begin
				start_rd = (pins.write_strobe_n == DIR_READ);
				start_wr = (pins.write_strobe_n != DIR_READ);
			end
			end_rd = !cs_prev_r && pins.first_channel_select_n;
			end_wr = end_rd;
		end
	end

	// One access per strobe edge; a new start is accepted only when idle
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			cyc_r <= DSHBP_IDLE;
			cyc_chan_r <= CHAN_FIRST;
		end else begin
			unique case (cyc_r)
				DSHBP_IDLE: begin
					cyc_chan_r <= sel_chan;
					if (start_rd) begin
						cyc_r <= DSHBP_READ;
					end else if (start_wr) begin
						cyc_r <= DSHBP_WRITE;
					end
				end
				DSHBP_READ: begin
					if (end_rd) begin
						cyc_r <= DSHBP_IDLE;
					end
				end
				DSHBP_WRITE: begin
					if (end_wr) begin
						cyc_r <= DSHBP_IDLE;
					end
				end
			endcase
		end
	end

	// Access strobes toward the channel register files
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			acc_r <= '0;
		end else begin
			acc_r.rd <= (cyc_r == DSHBP_IDLE) && start_rd;
			acc_r.wr <= (cyc_r == DSHBP_WRITE) && end_wr;
			if ((cyc_r == DSHBP_IDLE) && start_rd) begin
				acc_r.chan <= sel_chan;
				acc_r.addr <= pins.reg_addr;
			end else if ((cyc_r == DSHBP_WRITE) && end_wr) begin
				// Address and data are taken at the closing edge, where the host holds them
				acc_r.chan <= cyc_chan_r;
				acc_r.addr <= pins.reg_addr;
				acc_r.wdata <= pins.data;
			end
		end
	end

	assign acc_o = acc_r;

	// Read data is caught the cycle after the read pulse and held to the strobe end
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			rd_fill_r <= 1'b0;
			data_r <= DATA_RST;
			data_oe_o <= 1'b0;
		end else begin
			rd_fill_r <= acc_r.rd;
			if (acc_r.rd) begin
				data_r <= (acc_r.chan == CHAN_SECOND) ? second_rd_data_i : first_rd_data_i;
			end
			if (cyc_r != DSHBP_READ || end_rd) begin
				data_oe_o <= 1'b0;
			end else if (rd_fill_r) begin
				data_oe_o <= 1'b1;
			end
		end
	end

	assign data_o = data_r;

	// Auxiliary pins and irq enables follow each channel's out2 control bit, except the shared first irq pin in single-strobe style
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			first_channel_irq_o <= 1'b0;
			first_channel_irq_oe_o <= 1'b0;
			second_channel_irq_o <= 1'b0;
			second_channel_irq_oe_o <= 1'b0;
			first_aux_out2_n_o <= AUX_OUT2_N_RST;
			second_aux_out2_n_o <= AUX_OUT2_N_RST;
		end else begin
			first_aux_out2_n_o <= !first_stat_i.out2_ctrl_bit;
			second_aux_out2_n_o <= !second_stat_i.out2_ctrl_bit;
			if (dual) begin
				first_channel_irq_o <= first_stat_i.irq;
				first_channel_irq_oe_o <= first_stat_i.out2_ctrl_bit;
			end else begin
				// Open drain: only ever pulls low, the board pull-up gives the idle high
				first_channel_irq_o <= 1'b0;
				first_channel_irq_oe_o <= first_stat_i.irq || second_stat_i.irq;
			end
			second_channel_irq_o <= second_stat_i.irq;
			second_channel_irq_oe_o <= second_stat_i.out2_ctrl_bit;
		end
	end

	// Ready pins are active low copies of the channel status
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			first_tx_ready_n_o <= READY_N_RST;
			first_rx_ready_n_o <= READY_N_RST;
			second_tx_ready_n_o <= READY_N_RST;
			second_rx_ready_n_o <= READY_N_RST;
		end else begin
			first_tx_ready_n_o <= !first_stat_i.tx_ready;
			second_tx_ready_n_o <= !second_stat_i.tx_ready;
			first_rx_ready_n_o <= !first_stat_i.rx_ready;
			second_rx_ready_n_o <= !second_stat_i.rx_ready;
		end
	end

endmodule // dshbp_port
`default_nettype wire

// ===== core/dshbp_sync.sv
// Two-flop synchroniser for a bundle of asynchronous pin inputs
`timescale 1ns/10ps
`default_nettype none
module dshbp_sync
	import dshbp_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	// Asynchronous bundle in, synchronised bundle out
	input wire logic [PIN_BUNDLE_W-1:0] async_i,
	input wire logic [PIN_BUNDLE_W-1:0] rst_val_i,
	output logic [PIN_BUNDLE_W-1:0] sync_o
);

	logic [PIN_BUNDLE_W-1:0] meta_r;
	logic [PIN_BUNDLE_W-1:0] sync_r;

	// Reset value is a tied constant from the parent; the first stage feeds only the second
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			meta_r <= rst_val_i;
			sync_r <= rst_val_i;
		end else begin
			meta_r <= async_i;
			sync_r <= meta_r;
		end
	end

	assign sync_o = sync_r;

endmodule // dshbp_sync
`default_nettype wire

// ===== tb/dshbp_checker.sv
// Concurrent checks on the pins and access outputs of the host bus port
`timescale 1ns/10ps
`default_nettype none
module dshbp_checker
	import dshbp_pkg::*;
(
	// Clock, reset and host pins
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic bus_style_i,
	input wire logic read_strobe_n_i,
	input wire logic write_strobe_n_i,
	input wire logic first_channel_select_n_i,
	input wire logic [7:0] data_o,
	input wire logic data_oe_o,
	// Interrupt, auxiliary and ready pins
	input wire logic first_channel_irq_o,
	input wire logic first_channel_irq_oe_o,
	input wire logic second_channel_irq_o,
	input wire logic second_channel_irq_oe_o,
	input wire logic first_aux_out2_n_o,
	input wire logic second_aux_out2_n_o,
	input wire logic first_tx_ready_n_o,
	input wire logic first_rx_ready_n_o,
	input wire logic second_tx_ready_n_o,
	input wire logic second_rx_ready_n_o,
	// Channel side
	input wire dshbp_acc_t acc_o,
	input wire logic [7:0] first_rd_data_i,
	input wire logic [7:0] second_rd_data_i,
	input wire dshbp_chan_stat_t first_stat_i,
	input wire dshbp_chan_stat_t second_stat_i
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);
	// Style must have settled through the synchroniser before the pins follow it
	sequence s_dual_up; (rstn_i && bus_style_i)[*5]; endsequence
	sequence s_single_up; (rstn_i && !bus_style_i)[*5]; endsequence
	sequence s_up; rstn_i[*3]; endsequence
	property p_irq1; s_dual_up |-> first_channel_irq_oe_o == $past(first_stat_i.out2_ctrl_bit)
		&& first_channel_irq_o == $past(first_stat_i.irq); endproperty
	a_irq1: assert property (p_irq1) else $error("first irq pin wrong in two-strobe style");
	property p_aux; s_up |-> first_aux_out2_n_o == !$past(first_stat_i.out2_ctrl_bit)
		&& second_aux_out2_n_o == !$past(second_stat_i.out2_ctrl_bit); endproperty
	a_aux: assert property (p_aux) else $error("aux out2 pin wrong");
	property p_irq2; s_up |-> second_channel_irq_oe_o == $past(second_stat_i.out2_ctrl_bit)
		&& second_channel_irq_o == $past(second_stat_i.irq); endproperty
	a_irq2: assert property (p_irq2) else $error("second irq enable wrong");
	property p_shared; s_single_up |-> !first_channel_irq_o
		&& first_channel_irq_oe_o == $past(first_stat_i.irq || second_stat_i.irq); endproperty
	a_shared: assert property (p_shared) else $error("shared irq pin wrong");
	property p_rdy; s_up |-> {first_tx_ready_n_o, first_rx_ready_n_o, second_tx_ready_n_o,
		second_rx_ready_n_o} == ~$past({first_stat_i.tx_ready, first_stat_i.rx_ready,
		second_stat_i.tx_ready, second_stat_i.rx_ready}); endproperty
	a_rdy: assert property (p_rdy) else $error("ready pins wrong");
	property p_pulse; (acc_o.rd || acc_o.wr) |=> !(acc_o.rd || acc_o.wr)[*4]; endproperty
	a_pulse: assert property (p_pulse) else $error("access repeated for one strobe");
	sequence s_rd_fall; $fell(read_strobe_n_i) && !first_channel_select_n_i; endsequence
	property p_rdgo; s_dual_up ##0 s_rd_fall |-> ##[1:5] (acc_o.rd && acc_o.chan == CHAN_FIRST);
	endproperty
	a_rdgo: assert property (p_rdgo) else $error("read strobe gave no read");
	property p_rddata; acc_o.rd |=> data_o == ($past(acc_o.chan) ? $past(second_rd_data_i)
		: $past(first_rd_data_i)) ##1 data_oe_o; endproperty
	a_rddata: assert property (p_rddata) else $error("read byte not driven");
	sequence s_sel_fall; $fell(first_channel_select_n_i) && write_strobe_n_i == DIR_READ;
	endsequence
	property p_single; s_single_up ##0 s_sel_fall |-> ##[1:5] acc_o.rd; endproperty
	a_single: assert property (p_single) else $error("single-style read not started");
endmodule // dshbp_checker
`default_nettype wire

// ===== tb/dshbp_host_model.sv
// Host processor model that runs byte transfers on the parallel bus
`timescale 1ns/10ps
`default_nettype none
module dshbp_host_model
	import dshbp_pkg::*;
(
	// Clock and resolved data bus
	input wire logic clk_sys_i,
	input wire logic [7:0] dbus_i,
	// Host pins
	output var logic rs_n_o = STROBE_IDLE,
	output var logic ws_n_o = STROBE_IDLE,
	output var logic cs1_n_o = STROBE_IDLE,
	output var logic cs2_n_o = STROBE_IDLE,
	output var logic [2:0] addr_o = 3'h0,
	output var logic [7:0] data_o = 8'h00
);
	task automatic xfer(input logic dual, rd, ch, ign, input logic [2:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge clk_sys_i);
		#1;
		addr_o = a;
		data_o = d;
		if (dual) begin
			cs1_n_o = ign | ch;
			cs2_n_o = ign | !ch;
		end else begin
			cs2_n_o = ch;
			ws_n_o = rd ? DIR_READ : !DIR_READ;
		end
		repeat (2) @(posedge clk_sys_i);
		#1;
		if (!dual) cs1_n_o = 1'b0;
		else if (rd) rs_n_o = 1'b0;
		else ws_n_o = 1'b0;
		repeat (6) @(posedge clk_sys_i);
		q = dbus_i;
		#1;
		cs1_n_o = STROBE_IDLE;
		if (dual) {rs_n_o, ws_n_o} = 2'b11;
		repeat (4) @(posedge clk_sys_i);
		#1;
		// Released lines show the inverse so a stale value is never mistaken for data
		addr_o = ~a;
		data_o = ~d;
		cs2_n_o = dual ? STROBE_IDLE : !ch;
	endtask
endmodule // dshbp_host_model
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking testbench of the dual-style host bus port
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import dshbp_pkg::*;
;
	logic clk_sys_i = 1'b0;
	logic rstn_i = 1'b0;
	logic bus_style_i = STYLE_DUAL;
	wire logic rs_n, ws_n, cs1_n, cs2_n;
	wire logic [2:0] ra;
	wire logic [7:0] hd;
	logic [7:0] data_o, rd0, rd1;
	logic data_oe_o;
	dshbp_acc_t acc_o;
	dshbp_chan_stat_t st0 = '0;
	dshbp_chan_stat_t st1 = '0;
	logic [7:0] regs [16] = '{default: 8'h00};
	int exp_mem [16] = '{default: 0};
	int bad_count = 0;
	int samples_checked = 0;
	int cyc = 0;
	wire logic [7:0] dbus = data_oe_o ? data_o : hd;
	always #10 clk_sys_i = ~clk_sys_i;
	dshbp_host_model u_host (.clk_sys_i(clk_sys_i), .dbus_i(dbus), .rs_n_o(rs_n),
		.ws_n_o(ws_n), .cs1_n_o(cs1_n), .cs2_n_o(cs2_n), .addr_o(ra), .data_o(hd));
	dshbp_port u_dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .bus_style_i(bus_style_i),
		.read_strobe_n_i(rs_n), .write_strobe_n_i(ws_n), .first_channel_select_n_i(cs1_n),
		.second_channel_select_n_i(cs2_n), .reg_addr_bit2_i(ra[2]), .reg_addr_bit1_i(ra[1]),
		.reg_addr_bit0_i(ra[0]), .data_i(dbus), .data_o(data_o), .data_oe_o(data_oe_o),
		.first_channel_irq_o(), .first_channel_irq_oe_o(), .second_channel_irq_o(),
		.second_channel_irq_oe_o(), .first_aux_out2_n_o(), .second_aux_out2_n_o(),
		.first_tx_ready_n_o(), .first_rx_ready_n_o(), .second_tx_ready_n_o(),
		.second_rx_ready_n_o(), .acc_o(acc_o), .first_rd_data_i(rd0), .second_rd_data_i(rd1),
		.first_stat_i(st0), .second_stat_i(st1));
	// Channel register files answer combinationally, as the port expects
	assign rd0 = regs[{CHAN_FIRST, acc_o.addr}];
	assign rd1 = regs[{CHAN_SECOND, acc_o.addr}];
	always @(posedge clk_sys_i) begin
		if (acc_o.wr) regs[{acc_o.chan, acc_o.addr}] <= acc_o.wdata;
		#1 {st0, st1} = 8'($urandom);
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	// Ceiling well above the two passes of transfers
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			summarize();
		end
	end
	initial begin
		logic rd, ign;
		logic [3:0] k;
		logic [7:0] d, q;
		void'($urandom(32'h407eed40));
		for (int s = 0; s < 2; s++) begin
			// Reset and strap move off the edge, like every other input
			#1 rstn_i = 1'b0;
			bus_style_i = (s == 0) ? STYLE_DUAL : !STYLE_DUAL;
			repeat (8) @(posedge clk_sys_i);
			#1 rstn_i = 1'b1;
			for (int i = 0; i < 48; i++) begin
				k = 4'($urandom);
				d = 8'($urandom);
				rd = 1'($urandom);
				// Both selects high in two-strobe style must leave every register alone
				ign = (s == 0) && (($urandom % 8) == 0);
				u_host.xfer(s == 0, rd, k[3], ign, k[2:0], d, q);
				if (!rd && !ign) exp_mem[k] = d;
				if (rd && !ign) chk("read byte", exp_mem[k][7:0], q);
			end
			@(posedge clk_sys_i);
		end
		summarize();
	end
endmodule // tb_top
bind dshbp_port dshbp_checker u_chk (
	.clk_sys_i(clk_sys_i),
	.rstn_i(rstn_i),
	.bus_style_i(bus_style_i),
	.read_strobe_n_i(read_strobe_n_i),
	.write_strobe_n_i(write_strobe_n_i),
	.first_channel_select_n_i(first_channel_select_n_i),
	.data_o(data_o),
	.data_oe_o(data_oe_o),
	.first_channel_irq_o(first_channel_irq_o),
	.first_channel_irq_oe_o(first_channel_irq_oe_o),
	.second_channel_irq_o(second_channel_irq_o),
	.second_channel_irq_oe_o(second_channel_irq_oe_o),
	.first_aux_out2_n_o(first_aux_out2_n_o),
	.second_aux_out2_n_o(second_aux_out2_n_o),
	.first_tx_ready_n_o(first_tx_ready_n_o),
	.first_rx_ready_n_o(first_rx_ready_n_o),
	.second_tx_ready_n_o(second_tx_ready_n_o),
	.second_rx_ready_n_o(second_rx_ready_n_o),
	.acc_o(acc_o),
	.first_rd_data_i(first_rd_data_i),
	.second_rd_data_i(second_rd_data_i),
	.first_stat_i(first_stat_i),
	.second_stat_i(second_stat_i)
);
`default_nettype wire
